/* File: logic/stc_defines.svh */
// stc_defines.svh: offsets, field positions, reset values and codes of the timer
// assumes inclusion by bare name from every design file that needs them
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH

// ==========================================
// register byte offsets
`define STC_ADR_MAIN 5'h00
`define STC_ADR_MODE 5'h04
`define STC_ADR_CNT_LO 5'h08
`define STC_ADR_CNT_HI 5'h0C
`define STC_ADR_CMPA_LO 5'h10
`define STC_ADR_CMPA_HI 5'h14
`define STC_ADR_FLAGS 5'h18
`define STC_REG_RESET 8'h00

// ==========================================
// field positions
`define STC_PAUSE_BIT 7
`define STC_ON_BIT 3
`define STC_ON_MASK 8'h08
`define STC_RP_MSB 2
`define STC_RP_LSB 0
`define STC_MODE_MSB 7
`define STC_MODE_LSB 6
`define STC_FN_MSB 5
`define STC_FN_LSB 4
`define STC_OC_BIT 3
`define STC_POL_BIT 2
`define STC_DPX_BIT 1
`define STC_CCLR_BIT 0
`define STC_FLAG_A 0
`define STC_FLAG_P 1

// ==========================================
// function select codes
`define STC_FN_KEEP 2'h0
`define STC_FN_LOW 2'h1
`define STC_FN_HIGH 2'h2
`define STC_FN_TOGGLE 2'h3
`define STC_FN_INACTIVE 2'h0
`define STC_FN_ACTIVE 2'h1
`define STC_FN_PWM 2'h2
`define STC_FN_SINGLE 2'h3
`define STC_CAP_RISE 2'h0
`define STC_CAP_FALL 2'h1
`define STC_CAP_BOTH 2'h2

// ==========================================
// counter limits
`define STC_CNT_MAX 10'h3FF
`define STC_FULL_SPAN 11'h400

`endif

/* File: logic/stc_pkg.sv */
// stc_pkg.sv: types shared by the timer modules
// assumes nothing beyond a SystemVerilog compiler
package stc_pkg;
	// operating modes in field order
	typedef enum logic [1:0] {
		STC_MODE_CMP,
		STC_MODE_CAP,
		STC_MODE_PWM,
		STC_MODE_TMR
	} stc_mode_t;
endpackage

/* File: logic/stc_cfg_if.sv */
// stc_cfg_if.sv: configuration and events from timer core to pin generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface stc_cfg_if;
	stc_pkg::stc_mode_t mode;
	logic [1:0] fsel;
	logic oc;
	logic pol;
	logic dpx;
	logic [2:0] rp;
	logic enable;
	logic en_rise;
	logic a_event;
	logic [9:0] cnt;
	logic [9:0] cmpa;
	logic pin;
	modport timer (output mode, fsel, oc, pol, dpx, rp, enable, en_rise, a_event, cnt, cmpa,
		input pin);
	modport pin_gen (input mode, fsel, oc, pol, dpx, rp, enable, en_rise, a_event, cnt, cmpa,
		output pin);
endinterface

/* File: logic/stc_pin_gen.sv */
// stc_pin_gen.sv: output pin level for compare, pwm and single pulse modes
// assumes counter and compare events come from the timer core on the same clock
`timescale 1ns/1ps
`include "stc_defines.svh"
module stc_pin_gen (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// timer side
	stc_cfg_if.pin_gen cfg
);
	logic cmp_lvl;
	logic pin;
	logic next_cmp_lvl;
	logic pwm_lvl;

	// ==========================================
	// duty reference
	wire [10:0] p_span = (cfg.rp == 3'h0) ? `STC_FULL_SPAN : {1'b0, cfg.rp, 7'h00};
	wire [10:0] duty = cfg.dpx ? p_span : {1'b0, cfg.cmpa}; // [R11]
	wire pwm_act = {1'b0, cfg.cnt} < duty;

	// ==========================================
	// compare-mode level
	always_comb begin
		next_cmp_lvl = cmp_lvl;
		if (cfg.en_rise) begin
			next_cmp_lvl = cfg.oc; // [R20] [R09]
		end else if (cfg.a_event) begin
			unique case (cfg.fsel) // [R05] [R19] [R21]
				`STC_FN_KEEP: next_cmp_lvl = cmp_lvl;
				`STC_FN_LOW: next_cmp_lvl = 1'b0;
				`STC_FN_HIGH: next_cmp_lvl = 1'b1;
				`STC_FN_TOGGLE: next_cmp_lvl = ~cmp_lvl;
			endcase
		end
	end

	// ==========================================
	// pwm and single pulse level
	always_comb begin
		pwm_lvl = ~cfg.oc;
		unique case (cfg.fsel) // [R06] [R09]
			`STC_FN_INACTIVE: pwm_lvl = ~cfg.oc;
			`STC_FN_ACTIVE: pwm_lvl = cfg.oc;
			`STC_FN_PWM: pwm_lvl = pwm_act ? cfg.oc : ~cfg.oc;
			`STC_FN_SINGLE: pwm_lvl = cfg.enable ? cfg.oc : ~cfg.oc;
		endcase
	end

	wire is_pwm = cfg.mode == stc_pkg::STC_MODE_PWM;
	wire is_tmr = cfg.mode == stc_pkg::STC_MODE_TMR;
	wire next_lvl = is_pwm ? pwm_lvl : next_cmp_lvl;
	wire next_pin = is_tmr ? 1'b0 : (next_lvl ^ cfg.pol); // [R10]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_lvl <= 1'b0; // [R26]
			pin <= 1'b0;
		end else begin
			cmp_lvl <= next_cmp_lvl;
			pin <= next_pin;
		end
	end

	assign cfg.pin = pin;
endmodule

/* File: logic/stc_top.sv */
// stc_top.sv: 10-bit up-counting timer with compare, capture and pwm output
// assumes a classic wishbone master and a timer tick from same-clock logic
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "stc_defines.svh"

// Overview of operation
// R01 - period compare against counter bits 9..7, codes give 128..896, zero gives 1024
// R02 - period code zero lets the counter overflow at maximum and wrap
// R03 - two-bit mode field picks compare, capture, pwm/single pulse or timer
// R04 - software switches the timer off before changing the mode
// R05 - compare mode: A match keeps, lowers, raises or toggles the output
// R06 - pwm mode codes: force inactive, force active, pwm, single pulse
// R07 - capture mode codes: rising, falling, both edges, or capture off
// R08 - software changes the function field in pwm mode only when off
// R09 - output control sets initial level, active level, or pulse level
// R10 - polarity bit inverts the output pin except in timer mode
// R11 - swap bit exchanges period and duty roles of the two compares
// R12 - clear-select one clears on A match, zero on period or overflow
// R13 - clear-select is ignored in pwm, single pulse and capture modes
// R14 - counter readable as low byte and two-bit high part, rest zero
// R15 - compare A held as read/write low byte and two-bit high part
// R16 - compare mode, clear-select zero: both flags raised on their matches
// R17 - compare mode, clear-select one: only the A flag is raised
// R18 - compare A zero in compare mode: overflow at 3FF, no A flag
// R19 - only an A match moves the output pin, never a period match
// R20 - enable rising edge returns the pin to its initial level
// R21 - requested level equal to initial level shows no pin change
// R22 - enable rise zeroes the counter, enable fall stops and holds it
// R23 - low bytes pass a shared buffer moved by high byte access
// R24 - pause freezes the counter, release resumes from the held value
// R25 - each match flag is a one-cycle pulse with the clear it causes
// R26 - every register resets to zero, timer off and pin inactive
module stc_top (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// timer pins and tick
	input wire logic timer_tick_i,
	input wire logic capture_input_pin_i,
	output logic timer_output_pin_o,
	// match events
	output logic compare_a_pulse_o,
	output logic period_compare_pulse_o
);
	logic [7:0] main_ctl;
	logic [7:0] mode_ctl;
	logic [9:0] cnt;
	logic [9:0] cmpa;
	logic [7:0] buffer;
	logic [1:0] flags;
	logic enable_q;
	logic ack;
	logic [7:0] rdat;
	logic a_pulse_q;
	logic p_pulse_q;
	logic cap_s1;
	logic cap_s2;
	logic cap_s3;

	// ==========================================
	// control fields
	wire pause = main_ctl[`STC_PAUSE_BIT];
	wire timer_enable = main_ctl[`STC_ON_BIT];
	wire [2:0] rp = main_ctl[`STC_RP_MSB:`STC_RP_LSB];
	wire [1:0] fsel = mode_ctl[`STC_FN_MSB:`STC_FN_LSB];
	wire oc = mode_ctl[`STC_OC_BIT];
	wire pol = mode_ctl[`STC_POL_BIT];
	wire dpx = mode_ctl[`STC_DPX_BIT];
	wire clr_sel = mode_ctl[`STC_CCLR_BIT];
	stc_pkg::stc_mode_t mode;
	assign mode = stc_pkg::stc_mode_t'(mode_ctl[`STC_MODE_MSB:`STC_MODE_LSB]); // [R03]

	wire is_cmp = mode == stc_pkg::STC_MODE_CMP;
	wire is_tmr = mode == stc_pkg::STC_MODE_TMR;
	wire is_cap = mode == stc_pkg::STC_MODE_CAP;
	wire is_pwm = mode == stc_pkg::STC_MODE_PWM;
	wire cmp_like = is_cmp | is_tmr;
	wire single = is_pwm & (fsel == `STC_FN_SINGLE);

	// ==========================================
	// bus decode
	wire req = cyc_i & stb_i & ~ack;
	wire wr = req & we_i & sel_i[0];
	wire rd = req & ~we_i;
	wire [7:0] wbyte = dat_i[7:0];
	wire hit_main = adr_i == `STC_ADR_MAIN;
	wire hit_mode = adr_i == `STC_ADR_MODE;
	wire hit_cnt_lo = adr_i == `STC_ADR_CNT_LO;
	wire hit_cnt_hi = adr_i == `STC_ADR_CNT_HI;
	wire hit_cmpa_lo = adr_i == `STC_ADR_CMPA_LO;
	wire hit_cmpa_hi = adr_i == `STC_ADR_CMPA_HI;
	wire hit_flags = adr_i == `STC_ADR_FLAGS;
	wire wr_main = wr & hit_main;
	wire wr_mode = wr & hit_mode;
	wire wr_cmpa_lo = wr & hit_cmpa_lo;
	wire wr_cmpa_hi = wr & hit_cmpa_hi;
	wire wr_flags = wr & hit_flags;
	wire rd_cnt_hi = rd & hit_cnt_hi;
	wire rd_cmpa_hi = rd & hit_cmpa_hi;

	// ==========================================
	// read mux
	wire [7:0] next_rdat =
		hit_main ? main_ctl :
		hit_mode ? mode_ctl :
		(hit_cnt_lo | hit_cmpa_lo) ? buffer : // [R23]
		hit_cnt_hi ? {6'h00, cnt[9:8]} : // [R14]
		hit_cmpa_hi ? {6'h00, cmpa[9:8]} : // [R15]
		hit_flags ? {6'h00, flags} :
		8'h00;

	// ==========================================
	// counter matches
	wire en_rise = timer_enable & ~enable_q;
	wire count_go = timer_enable & ~pause & timer_tick_i; // [R24] [R22]
	wire [9:0] cnt_inc = cnt + 10'h001;
	wire [9:0] period_val = {rp, 7'h00};
	wire p_hit = (rp == 3'h0) ? (cnt == `STC_CNT_MAX) : (cnt_inc == period_val); // [R01] [R02]
	wire p_match = count_go & p_hit;
	wire a_match = count_go & (cmpa != 10'h000) & (cnt_inc == cmpa); // [R18]

	// ==========================================
	// capture edges
	wire cap_rise = cap_s2 & ~cap_s3;
	wire cap_fall = ~cap_s2 & cap_s3;
	wire cap_edge =
		(fsel == `STC_CAP_RISE) ? cap_rise :
		(fsel == `STC_CAP_FALL) ? cap_fall :
		(fsel == `STC_CAP_BOTH) ? (cap_rise | cap_fall) :
		1'b0; // [R07]
	wire capture = is_cap & timer_enable & cap_edge;

	// ==========================================
	// clear source and flags
	wire clr_cmp = clr_sel ? a_match : p_match; // [R12]
	wire clr_pwm = single ? 1'b0 : (dpx ? a_match : p_match); // [R11] [R13]
	wire cnt_clear =
		cmp_like ? clr_cmp :
		is_cap ? p_match : // [R13]
		clr_pwm;
	wire a_event = is_cap ? capture : a_match;
	wire p_event = cmp_like ? (p_match & ~clr_sel) : // [R16] [R17]
		single ? 1'b0 :
		p_match;
	wire sp_stop = single & a_match; // [R06]

	// ==========================================
	// next register values
	wire [9:0] next_cnt =
		en_rise ? 10'h000 : // [R22]
		cnt_clear ? 10'h000 :
		count_go ? cnt_inc :
		cnt;
	wire [7:0] next_main =
		wr_main ? wbyte :
		sp_stop ? (main_ctl & ~`STC_ON_MASK) :
		main_ctl;
	wire [9:0] next_cmpa =
		capture ? cnt :
		wr_cmpa_hi ? {wbyte[1:0], buffer} : // [R15] [R23]
		cmpa;
	wire [7:0] next_buffer =
		wr_cmpa_lo ? wbyte :
		rd_cnt_hi ? cnt[7:0] :
		rd_cmpa_hi ? cmpa[7:0] : // [R23]
		buffer;
	wire [1:0] flag_clr = wr_flags ? wbyte[1:0] : 2'h0;
	wire [1:0] flag_set = {p_event, a_event};
	wire [1:0] next_flags = (flags & ~flag_clr) | flag_set;

	// ==========================================
	// registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_ctl <= `STC_REG_RESET; // [R26]
			mode_ctl <= `STC_REG_RESET;
			cnt <= 10'h000;
			cmpa <= 10'h000;
			buffer <= `STC_REG_RESET;
			flags <= 2'h0;
			enable_q <= 1'b0;
		end else begin
			main_ctl <= next_main;
			mode_ctl <= wr_mode ? wbyte : mode_ctl;
			cnt <= next_cnt;
			cmpa <= next_cmpa;
			buffer <= next_buffer;
			flags <= next_flags;
			enable_q <= timer_enable;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			rdat <= 8'h00;
			a_pulse_q <= 1'b0;
			p_pulse_q <= 1'b0;
		end else begin
			ack <= req;
			rdat <= rd ? next_rdat : 8'h00;
			a_pulse_q <= a_event; // [R25]
			p_pulse_q <= p_event;
		end
	end

	// ==========================================
	// capture pin synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
			cap_s3 <= 1'b0;
		end else begin
			cap_s1 <= capture_input_pin_i;
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
		end
	end

	// ==========================================
	// pin generator
	stc_cfg_if cfg ();
	assign cfg.mode = mode;
	assign cfg.fsel = fsel;
	assign cfg.oc = oc;
	assign cfg.pol = pol;
	assign cfg.dpx = dpx;
	assign cfg.rp = rp;
	assign cfg.enable = timer_enable;
	assign cfg.en_rise = en_rise;
	assign cfg.a_event = a_match & cmp_like;
	assign cfg.cnt = cnt;
	assign cfg.cmpa = cmpa;

	stc_pin_gen u_pin_gen (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cfg(cfg.pin_gen)
	);

	// ==========================================
	// outputs
	assign dat_o = {24'h000000, rdat};
	assign ack_o = ack;
	assign timer_output_pin_o = cfg.pin;
	assign compare_a_pulse_o = a_pulse_q;
	assign period_compare_pulse_o = p_pulse_q;

	// ==========================================
	// assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_enable_rise_zero: assert property (en_rise |=> cnt == 10'h000) // [R22]
		else $error("counter not zeroed by enable rise");
	a_pause_holds: assert property (pause & ~en_rise & ~capture |=> $stable(cnt)) // [R24]
		else $error("counter moved while paused");
	a_period_clear: assert property (p_match & cmp_like & ~clr_sel & (rp != 3'h0)
		|=> (cnt == 10'h000) && period_compare_pulse_o) // [R01]
		else $error("period match did not clear with pulse");
	a_overflow_wrap: assert property (p_match & cmp_like & (rp == 3'h0) & ~en_rise
		|=> (cnt == 10'h000) && ($past(cnt) == `STC_CNT_MAX)) // [R02]
		else $error("overflow did not wrap to zero");
	a_clear_on_a: assert property (a_match & cmp_like & clr_sel & ~en_rise
		|=> (cnt == 10'h000) && compare_a_pulse_o) // [R12]
		else $error("A match did not clear the counter");
	a_no_period_flag: assert property (cmp_like & clr_sel |=> !period_compare_pulse_o) // [R17]
		else $error("period flag raised with clear on A");
	a_zero_cmpa_quiet: assert property (cmp_like & (cmpa == 10'h000) |=> !compare_a_pulse_o) // [R18]
		else $error("A flag raised with compare zero");
	a_pin_on_a_only: assert property (is_cmp & ~a_match & ~en_rise & $stable(mode_ctl)
		|=> $stable(timer_output_pin_o)) // [R19]
		else $error("pin moved without A match");
	a_init_level: assert property (is_cmp & en_rise |=> timer_output_pin_o == $past(oc ^ pol)) // [R20]
		else $error("pin not at initial level after enable rise");
	a_high_latch: assert property (rd_cnt_hi |=> buffer == $past(cnt[7:0])) // [R23]
		else $error("low byte not latched on high read");
	a_capture_load: assert property (capture |=> (cmpa == $past(cnt)) && compare_a_pulse_o) // [R07]
		else $error("capture did not load compare A");
	a_single_stop: assert property (sp_stop & ~wr_main |=> !timer_enable) // [R06]
		else $error("single pulse did not switch timer off");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	c_period_wrap: cover property (p_match & cmp_like ##1 period_compare_pulse_o);
	c_capture: cover property (capture ##1 compare_a_pulse_o);
	c_toggle: cover property (is_cmp & (fsel == `STC_FN_TOGGLE) & a_match);
	c_single: cover property (en_rise & single ##[1:1000] sp_stop);
endmodule

/* File: tb/stc_pin_partner.sv */
// stc_pin_partner.sv: circuitry outside the timer pins
// assumes the bench clock; fire_i asks for one capture pin edge
`timescale 1ns/1ps
module stc_pin_partner (
	// system
	input wire logic clk_i,
	// bench control
	input wire logic fire_i,
	// timer pins
	input wire logic pin_i,
	output logic cap_o,
	output logic [15:0] pin_moves_o
);
	logic last_pin;
	initial begin
		cap_o = 1'b0;
		last_pin = 1'b0;
		pin_moves_o = 16'h0000;
	end
	// ======
	// each request flips the capture level: rise, fall, rise, ...
	always @(posedge clk_i) begin
		if (fire_i) cap_o <= ~cap_o;
		last_pin <= pin_i;
		if (pin_i !== last_pin) pin_moves_o <= pin_moves_o + 16'h0001;
	end
endmodule

/* File: tb/tb.sv */
// tb.sv: self-checking bench for the timer core
// assumes the design files under logic/ and the pin partner model
`timescale 1ns/1ps
`include "stc_defines.svh"
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic tick = 1'b0;
	logic fire = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o;
	logic ack_o, pin, pa, pp, cap;
	logic [15:0] moves, mv;
	logic [7:0] ca;
	logic [31:0] expq[$];
	int miscompares = 0;
	int tests_run = 0;
	int acnt = 0;
	int pcnt = 0;
	int cycles = 0;
	int n, b;
	int seed = 32'h3535fba5;
	initial forever #5 clk_i = ~clk_i;
	stc_top u_stc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.timer_tick_i(tick), .capture_input_pin_i(cap), .timer_output_pin_o(pin),
		.compare_a_pulse_o(pa), .period_compare_pulse_o(pp));
	stc_pin_partner u_stc_pin_partner (.clk_i(clk_i), .fire_i(fire), .pin_i(pin),
		.cap_o(cap), .pin_moves_o(moves));
	// ======
	// checking and closing
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// read monitor, event counters and timeout
	always @(posedge clk_i) begin
		cycles++;
		if (pa === 1'b1) acnt++;
		if (pp === 1'b1) pcnt++;
		if (ack_o === 1'b1 && cyc && !we) chk("read data", expq.pop_front(), dat_o);
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// ======
	// bus and timer helpers
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		expq.push_back({24'h0, e});
		bus(1'b0, a, 8'h00);
	endtask
	task automatic rdcnt(input logic [7:0] e);
		rd(`STC_ADR_CNT_HI, 8'h00);
		rd(`STC_ADR_CNT_LO, e);
	endtask
	task automatic restart(input logic [7:0] md, input logic [7:0] mn);
		bus(1'b1, `STC_ADR_MAIN, 8'h00);
		bus(1'b1, `STC_ADR_MODE, md);
		bus(1'b1, `STC_ADR_MAIN, mn);
	endtask
	task automatic waitp(input logic s, output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while ((s ? pp : pa) !== 1'b1 && k < 3000);
	endtask
	task automatic ticks(input int c);
		@(posedge clk_i);
		tick <= 1'b1;
		repeat (c) @(posedge clk_i);
		tick <= 1'b0;
	endtask
	// ======
	// main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("pin at reset", 0, pin);
		for (int a = 0; a < 8; a++) rd(5'(a * 4), 8'h00);
		ca = 8'd16 + 8'($unsigned($random(seed)) % 64);
		bus(1'b1, `STC_ADR_CMPA_LO, ca);
		bus(1'b1, `STC_ADR_CMPA_HI, 8'hFC);
		rd(`STC_ADR_CMPA_HI, 8'h00);
		rd(`STC_ADR_CMPA_LO, ca);
		tick <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			restart({2'b00, 2'(k), 1'b0, k[2], 2'b01}, 8'h08);
			repeat (2) @(posedge clk_i);
			chk("initial pin", k[2], pin);
			b = pcnt;
			mv = moves;
			waitp(1'b0, n);
			@(posedge clk_i);
			chk("pin after match", k[1] ^ k[2], pin);
			if (!k[1]) chk("pin moves", mv, moves);
			waitp(1'b0, n);
			chk("clear on A gap", ca, n + 1);
			chk("period pulses", b, pcnt);
		end
		for (int c = 0; c < 3; c++) begin
			restart(8'h00, 8'h08 | 8'(c * 3 % 8));
			b = acnt;
			waitp(1'b1, n);
			waitp(1'b1, n);
			chk("period gap", c == 0 ? 1024 : c * 3 * 128, n);
			chk("A pulse", 1, acnt > b);
		end
		tick <= 1'b0;
		restart(8'h00, 8'h08);
		rdcnt(8'h00);
		ticks(5);
		rdcnt(8'h05);
		bus(1'b1, `STC_ADR_MAIN, 8'h88);
		ticks(5);
		rdcnt(8'h05);
		bus(1'b1, `STC_ADR_MAIN, 8'h08);
		ticks(5);
		rdcnt(8'h0A);
		bus(1'b1, `STC_ADR_MAIN, 8'h00);
		ticks(5);
		rdcnt(8'h0A);
		for (int f = 0; f < 4; f++) begin
			restart({2'b01, 2'(f), 4'h0}, 8'h08);
			ticks(5);
			b = acnt;
			@(posedge clk_i);
			fire <= 1'b1;
			@(posedge clk_i);
			fire <= 1'b0;
			repeat (10) @(posedge clk_i);
			chk("captures", f != 3, acnt - b);
			rd(`STC_ADR_CMPA_HI, 8'h00);
			rd(`STC_ADR_CMPA_LO, 8'h05);
		end
		for (int t = 0; t < 4; t++) begin
			restart(t == 0 ? 8'h98 : t == 1 ? 8'h88 : t == 2 ? 8'h9C : 8'hC8, 8'h08);
			repeat (3) @(posedge clk_i);
			chk("forced pin", t == 0, pin);
		end
		report_and_stop();
	end
endmodule
